// [logic/twau_pkg.sv]
// Package: constants for the table write access unit.
// Assumes: used as twau_pkg::name, never imported.
package twau_pkg;
	// ==========================================================
	// Pointer and holding register geometry
	localparam int PTR_W     = 21;
	localparam int HOLD_N    = 8;
	localparam int HOLD_IW   = 3;
	localparam int BYTE_W    = 8;
	// ==========================================================
	// Opcode layout: fixed upper 14 bits, then a two-bit mode
	localparam logic [13:0] OPC_WRITE = 14'h0003;
	localparam logic [13:0] OPC_READ  = 14'h0002;
	localparam logic [1:0]  MODE_KEEP = 2'h0;
	localparam logic [1:0]  MODE_POST_INC = 2'h1;
	localparam logic [1:0]  MODE_POST_DEC = 2'h2;
	localparam logic [1:0]  MODE_PRE_INC  = 2'h3;
	// ==========================================================
	// Reset values and phase counts
	localparam logic [20:0] PTR_RST   = 21'h00_0000;
	localparam logic [7:0]  LATCH_RST = 8'h00;
	localparam logic [7:0]  HOLD_RST  = 8'hFF;
	localparam logic [1:0]  Q_LAST    = 2'h3;
	localparam logic [1:0]  Q_READ    = 2'h1;

	typedef enum logic [2:0] {
		TWAU_IDLE  = 3'b001,
		TWAU_WRITE = 3'b010,
		TWAU_READ  = 3'b100
	} twau_state_t;
endpackage : twau_pkg

// [logic/twau_hold_if.sv]
// Interface: holding register write port between core and holding bank.
// Assumes: one clock, both ends on ref_clk_in.
`timescale 1ns/1ns
interface twau_hold_if;
	logic        we;
	logic [2:0]  idx;
	logic [7:0]  data;
	modport core (output we, output idx, output data);
	modport bank (input we, input idx, input data);
endinterface : twau_hold_if

// [logic/twau_hold_bank.sv]
// Module: the eight holding registers later used to program flash.
// Assumes: written only by the table write sequencer.
`timescale 1ns/1ns
module twau_hold_bank (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	// Write port
	twau_hold_if.bank       hold,
	// Contents
	output logic [63:0]     hold_data_out
);
	logic [7:0] hold_q [8];
	logic [7:0] hold_d [8];

	for (genvar i = 0; i < twau_pkg::HOLD_N; i++) begin : g_hold
		always_comb begin
			hold_d[i] = hold_q[i];
			if (hold.we && hold.idx == 3'(i)) begin
				hold_d[i] = hold.data; // RL1
			end
		end
		always_ff @(posedge clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				hold_q[i] <= twau_pkg::HOLD_RST;
			end else begin
				hold_q[i] <= hold_d[i];
			end
		end
		assign hold_data_out[i*8 +: 8] = hold_q[i];
	end
endmodule : twau_hold_bank

// [logic/twau_unit.sv]
// Module: table write / table read sequencer with pointer and latch.
// Assumes: instr_valid_in pulses in Q1 of an instruction cycle from the
// core decoder (same clock); one ref_clk_in edge is one Q phase.
// How it works
// RL1 - Latch byte goes to one of 8 holding registers, picked by pointer low bits.
// RL2 - Table write touches only holding registers, never program memory.
// RL3 - Pointer is 21 bits, byte addressing, two megabyte range.
// RL4 - Pointer bit 0 picks low (0) or high (1) byte of a word.
// RL5 - Post-decrement writes holding register then subtracts one from pointer.
// RL6 - Post-increment writes then adds one; pre-increment adds one then writes.
// RL7 - Four pointer treatments: unchanged, post-inc, post-dec, pre-inc.
// RL8 - Write opcode is fourteen fixed bits 0000_0000_0000_11 then mode.
// RL9 - Table read fetches memory byte at pointer into latch, same modes.
// RL10 - Two cycles, one word; latch read early, holding written at end.
`timescale 1ns/1ns
module twau_unit (
	// Clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rstn_in,
	// Instruction from decoder
	input  wire logic        instr_valid_in,
	input  wire logic [15:0] instr_word_in,
	// Latch and pointer loads from the core
	input  wire logic        latch_load_in,
	input  wire logic [7:0]  latch_value_in,
	input  wire logic        ptr_load_in,
	input  wire logic [20:0] ptr_value_in,
	// Program memory read port
	input  wire logic [7:0]  pmem_rdata_in,
	output logic [20:0]      pmem_addr_out,
	output logic             pmem_rd_out,
	// State seen by core and flash
	output logic [20:0]      table_pointer_out,
	output logic [7:0]       table_latch_out,
	output logic [63:0]      hold_data_out,
	output logic             busy_out,
	output logic             accepted_out
);
	// ==========================================================
	// Reset release
	logic rst_s1_q;
	logic rst_s2_q;
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	wire logic rstn = rst_s2_q;

	// ==========================================================
	// Decode
	logic is_write;
	logic is_read;
	assign is_write = instr_valid_in && instr_word_in[15:2] == twau_pkg::OPC_WRITE; // RL8
	assign is_read  = instr_valid_in && instr_word_in[15:2] == twau_pkg::OPC_READ;  // RL9
	assign accepted_out = (is_write || is_read) && !busy_out;

	// ==========================================================
	// Sequencer: Q phase counter over the decode and execute cycles
	twau_pkg::twau_state_t state_q, state_d;
	logic [1:0]  q_q, q_d;
	logic        cyc_q, cyc_d;
	logic [1:0]  mode_q, mode_d;
	logic [20:0] ptr_q, ptr_d;
	logic [20:0] addr_q, addr_d;
	logic [7:0]  lat_q, lat_d;
	logic [7:0]  wbyte_q, wbyte_d;
	logic        hold_we;
	logic        end_exec;

	twau_hold_if hold ();

	assign end_exec = cyc_q && q_q == twau_pkg::Q_LAST;

	always_comb begin
		state_d = state_q;
		q_d     = q_q + 2'h1;
		cyc_d   = cyc_q;
		mode_d  = mode_q;
		ptr_d   = ptr_q;
		addr_d  = addr_q;
		lat_d   = lat_q;
		wbyte_d = wbyte_q;
		hold_we = 1'b0;
		if (latch_load_in) begin
			lat_d = latch_value_in;
		end
		if (ptr_load_in) begin
			ptr_d = ptr_value_in;
		end
		case (state_q)
			twau_pkg::TWAU_IDLE: begin
				q_d = 2'h0;
				if (accepted_out) begin
					state_d = is_write ? twau_pkg::TWAU_WRITE : twau_pkg::TWAU_READ;
					mode_d  = instr_word_in[1:0]; // RL7
					q_d     = 2'h1;
					cyc_d   = 1'b0;
					// Pre-increment moves the pointer before the access
					if (instr_word_in[1:0] == twau_pkg::MODE_PRE_INC) begin
						addr_d = ptr_q + 21'h00_0001; // RL6
					end else begin
						addr_d = ptr_q;
					end
				end
			end
			twau_pkg::TWAU_WRITE, twau_pkg::TWAU_READ: begin
				if (q_q == twau_pkg::Q_LAST) begin
					cyc_d = 1'b1;
				end
				if (cyc_q && q_q == twau_pkg::Q_READ && state_q == twau_pkg::TWAU_WRITE) begin
					wbyte_d = lat_q; // RL10
				end
				if (end_exec) begin
					state_d = twau_pkg::TWAU_IDLE;
					cyc_d   = 1'b0;
					if (state_q == twau_pkg::TWAU_WRITE) begin
						hold_we = 1'b1; // RL2
					end else begin
						lat_d = pmem_rdata_in; // RL9
					end
					case (mode_q)
						twau_pkg::MODE_POST_INC: ptr_d = addr_q + 21'h00_0001; // RL6
						twau_pkg::MODE_POST_DEC: ptr_d = addr_q - 21'h00_0001; // RL5
						twau_pkg::MODE_PRE_INC:  ptr_d = addr_q;               // RL6
						default:                 ptr_d = addr_q;               // RL7
					endcase
				end
			end
			default: begin
				state_d = twau_pkg::TWAU_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rstn) begin
		if (!rstn) begin
			state_q <= twau_pkg::TWAU_IDLE;
			q_q     <= 2'h0;
			cyc_q   <= 1'b0;
			mode_q  <= twau_pkg::MODE_KEEP;
			ptr_q   <= twau_pkg::PTR_RST;
			addr_q  <= twau_pkg::PTR_RST;
			lat_q   <= twau_pkg::LATCH_RST;
			wbyte_q <= twau_pkg::LATCH_RST;
		end else begin
			state_q <= state_d;
			q_q     <= q_d;
			cyc_q   <= cyc_d;
			mode_q  <= mode_d;
			ptr_q   <= ptr_d; // RL3
			addr_q  <= addr_d;
			lat_q   <= lat_d;
			wbyte_q <= wbyte_d;
		end
	end

	// ==========================================================
	// Holding register port: bit 0 is the byte within the word
	assign hold.we   = hold_we;
	assign hold.idx  = addr_q[2:0]; // RL1 RL4
	assign hold.data = wbyte_q;

	twau_hold_bank u_bank (
		.clk_in        (ref_clk_in),
		.rstn_in       (rstn),
		.hold          (hold.bank),
		.hold_data_out (hold_data_out)
	);

	assign busy_out          = state_q != twau_pkg::TWAU_IDLE;
	assign table_pointer_out = ptr_q;
	assign table_latch_out   = lat_q;
	assign pmem_addr_out     = addr_q;
	// Memory is only read for table reads, never written here
	assign pmem_rd_out = state_q == twau_pkg::TWAU_READ && cyc_q; // RL2

	// ==========================================================
	// Checks
	sequence s_write_start;
		state_q == twau_pkg::TWAU_IDLE && accepted_out && is_write;
	endsequence

	chk_write_two_cycles: assert property (@(posedge ref_clk_in) disable iff (!rstn) // RL10
		s_write_start |-> ##7 hold_we ##1 !busy_out)
		else $error("holding write not at end of second cycle");
	chk_post_inc_ptr: assert property (@(posedge ref_clk_in) disable iff (!rstn) // RL6
		(end_exec && mode_q == twau_pkg::MODE_POST_INC && !ptr_load_in)
		|=> ptr_q == $past(addr_q) + 21'h00_0001)
		else $error("post increment wrong");
	chk_post_dec_ptr: assert property (@(posedge ref_clk_in) disable iff (!rstn) // RL5
		(end_exec && mode_q == twau_pkg::MODE_POST_DEC && !ptr_load_in)
		|=> ptr_q == $past(addr_q) - 21'h00_0001)
		else $error("post decrement wrong");
	chk_pre_inc_addr: assert property (@(posedge ref_clk_in) disable iff (!rstn) // RL6
		(s_write_start and instr_word_in[1:0] == twau_pkg::MODE_PRE_INC)
		|=> addr_q == $past(ptr_q) + 21'h00_0001)
		else $error("pre increment address wrong");
	chk_keep_ptr: assert property (@(posedge ref_clk_in) disable iff (!rstn) // RL7
		(end_exec && mode_q == twau_pkg::MODE_KEEP && !ptr_load_in)
		|=> ptr_q == $past(ptr_q))
		else $error("pointer changed in keep mode");
	chk_hold_index: assert property (@(posedge ref_clk_in) disable iff (!rstn) // RL1
		hold_we |=> hold_data_out[$past(addr_q[2:0])*8 +: 8] == $past(wbyte_q))
		else $error("holding register not written");
	chk_decode_write: assert property (@(posedge ref_clk_in) disable iff (!rstn) // RL8
		(!busy_out && instr_valid_in && instr_word_in[15:2] == 14'h0003)
		|=> state_q == twau_pkg::TWAU_WRITE)
		else $error("write opcode not taken");
	chk_read_latch: assert property (@(posedge ref_clk_in) disable iff (!rstn) // RL9
		(end_exec && state_q == twau_pkg::TWAU_READ && !latch_load_in)
		|=> lat_q == $past(pmem_rdata_in))
		else $error("latch not loaded by read");
	chk_no_mem_write: assert property (@(posedge ref_clk_in) disable iff (!rstn) // RL2
		state_q == twau_pkg::TWAU_WRITE |-> !pmem_rd_out)
		else $error("memory touched by write");
	chk_hold_unchanged: assert property (@(posedge ref_clk_in) disable iff (!rstn) // RL2
		!hold_we |=> $stable(hold_data_out))
		else $error("holding register changed without a table write");
endmodule : twau_unit

// [tb/twau_pmem_model.sv]
// Program memory model: a byte pattern made from the address.
// Assumes: same clock as the unit; read port as in the unit's header.
`timescale 1ns/1ns
module twau_pmem_model (
	// Clock
	input  wire logic        clk_in,
	// Read port
	input  wire logic [20:0] addr_in,
	input  wire logic        rd_in,
	output logic [7:0]       rdata_out
);
	// ==========================================================
	// Released bus shows the inverse of the last byte, so a stale sample fails
	logic [7:0] last_q = 8'h00;
	assign rdata_out = rd_in ? (addr_in[7:0] ^ {addr_in[20:16], 3'h5}) : ~last_q;
	always_ff @(posedge clk_in) begin
		if (rd_in) begin
			last_q <= addr_in[7:0] ^ {addr_in[20:16], 3'h5};
		end
	end
endmodule : twau_pmem_model

// [tb/tb_top.sv]
// Testbench for the table write access unit.
// Assumes: inputs change at the falling edge; unit answers 7 edges after taking.
`timescale 1ns/1ns
module tb_top;
	logic        clk      = 1'b0;
	logic        rstn     = 1'b0;
	logic        valid    = 1'b0;
	logic [15:0] word     = 16'h0000;
	logic        l_ld     = 1'b0;
	logic [7:0]  l_val    = 8'h00;
	logic        p_ld     = 1'b0;
	logic [20:0] p_val    = 21'h00_0000;
	logic [7:0]  rdata;
	logic [20:0] addr;
	logic [20:0] ptr;
	logic        rd;
	logic        busy;
	logic        acc;
	logic [7:0]  latch;
	logic [63:0] hold;
	logic [63:0] eh       = {8{8'hFF}};
	int          fail_count = 0;
	int          num_checks = 0;
	always #25 clk = ~clk;
	twau_unit dut (.ref_clk_in(clk), .rstn_in(rstn), .instr_valid_in(valid),
		.instr_word_in(word), .latch_load_in(l_ld), .latch_value_in(l_val),
		.ptr_load_in(p_ld), .ptr_value_in(p_val), .pmem_rdata_in(rdata),
		.pmem_addr_out(addr), .pmem_rd_out(rd), .table_pointer_out(ptr),
		.table_latch_out(latch), .hold_data_out(hold), .busy_out(busy),
		.accepted_out(acc));
	twau_pmem_model pmem (.clk_in(clk), .addr_in(addr), .rd_in(rd), .rdata_out(rdata));
	// ==========================================================
	// Compare and closing tasks
	task automatic chk_val(input logic [63:0] g, input logic [63:0] e, input string s);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error at %0t: %s got %h want %h", $time, s, g, e);
		end
	endtask : chk_val
	task automatic chk_bit(input logic g, input logic e, input string s);
		chk_val({63'h0, g}, {63'h0, e}, s);
	endtask : chk_bit
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop
	// ==========================================================
	// Drivers
	task automatic load(input logic [20:0] p, input logic [7:0] l);
		@(negedge clk);
		p_ld = 1'b1;
		p_val = p;
		l_ld = 1'b1;
		l_val = l;
		@(negedge clk);
		p_ld = 1'b0;
		l_ld = 1'b0;
	endtask : load
	task automatic issue(input logic [15:0] w, input logic ea, input logic er, input int nc);
		int n;
		logic seen;
		n = 0;
		seen = 1'b0;
		@(negedge clk);
		valid = 1'b1;
		word = w;
		#1;
		chk_bit(acc, ea, "accepted");
		@(negedge clk);
		valid = 1'b0;
		while (busy !== 1'b0 && n < 20) begin
			seen = seen | rd;
			@(negedge clk);
			n++;
		end
		chk_val(64'(n), 64'(nc), "cycles");
		chk_bit(seen, er, "read strobe");
	endtask : issue
	// ==========================================================
	// Scenarios
	task automatic t_op(input logic rdop, input logic [1:0] m, input logic [20:0] p);
		logic [20:0] np;
		logic [20:0] a;
		logic [7:0]  el;
		np = (m == twau_pkg::MODE_KEEP) ? p : p + 21'h00_0001;
		np = (m == twau_pkg::MODE_POST_DEC) ? p - 21'h00_0001 : np;
		a = (m == twau_pkg::MODE_PRE_INC) ? np : p;
		el = rdop ? (a[7:0] ^ {a[20:16], 3'h5}) : p[7:0] ^ 8'h5C;
		load(p, p[7:0] ^ 8'h5C);
		if (!rdop) begin
			eh[{a[2:0], 3'h0} +: 8] = el;
		end
		issue({rdop ? twau_pkg::OPC_READ : twau_pkg::OPC_WRITE, m}, 1'b1, rdop, 7);
		chk_val(hold, eh, "holding");
		chk_val(64'(ptr), 64'(np), "pointer");
		chk_val(64'(latch), 64'(el), "latch");
		$display("test op read=%0d mode=%0d done", rdop, m);
	endtask : t_op
	task automatic t_busy;
		load(21'h00_0005, 8'h3C);
		eh[47:40] = 8'h3C;
		@(negedge clk);
		valid = 1'b1;
		word = {twau_pkg::OPC_WRITE, twau_pkg::MODE_KEEP};
		@(negedge clk);
		valid = 1'b0;
		issue({twau_pkg::OPC_WRITE, twau_pkg::MODE_POST_INC}, 1'b0, 1'b0, 5);
		chk_val(64'(ptr), 64'h5, "pointer");
		chk_val(hold, eh, "holding");
		issue(16'h0010, 1'b0, 1'b0, 0);
		issue(16'h010C, 1'b0, 1'b0, 0);
		chk_val(64'(ptr), 64'h5, "pointer");
		chk_val(hold, eh, "holding");
		$display("test refusal done");
	endtask : t_busy
	initial begin
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		chk_val(64'(ptr), 64'h0, "pointer");
		chk_val(64'(latch), 64'h0, "latch");
		chk_val(hold, eh, "holding");
		chk_bit(busy, 1'b0, "busy");
		$display("test reset done");
		t_op(1'b0, twau_pkg::MODE_KEEP, 21'h00_A356);
		t_op(1'b0, twau_pkg::MODE_POST_INC, 21'h00_A356);
		t_op(1'b0, twau_pkg::MODE_POST_DEC, 21'h00_0000);
		t_op(1'b0, twau_pkg::MODE_PRE_INC, 21'h01_389A);
		t_op(1'b0, twau_pkg::MODE_PRE_INC, 21'h1F_FFFF);
		t_op(1'b1, twau_pkg::MODE_KEEP, 21'h00_A356);
		t_op(1'b1, twau_pkg::MODE_POST_INC, 21'h1A_3357);
		t_op(1'b1, twau_pkg::MODE_POST_DEC, 21'h00_0001);
		t_op(1'b1, twau_pkg::MODE_PRE_INC, 21'h01_A357);
		t_busy();
		report_and_stop();
	end
	initial begin
		repeat (3000) @(posedge clk);
		fail_count++;
		$display("Error at %0t: watchdog expired", $time);
		report_and_stop();
	end
endmodule : tb_top
